// ---- logic/ioa_alu.sv ----
// Accumulator arithmetic and logic, purely combinational.
// Operands come from the core's registers on the same clock.
`timescale 1ns/1ps
module ioa_alu
  import ioa_pkg::*;
(
  // Operation and operands
  input  wire logic [7:0]  op_in,
  input  wire logic [31:0] acc_in,
  input  wire logic [31:0] operand_in,
  // Result
  output logic      [31:0] result_out,
  output logic             ok_out
);

  logic signed [31:0] a;
  logic signed [31:0] b;

  assign a = acc_in;
  assign b = operand_in;

  // All results stay 32 bits and wrap
  always_comb begin
    result_out = acc_in;
    ok_out     = 1'b1;
    case (op_in)
      IOA_OP_ADD:  result_out = a + b;
      IOA_OP_SUB:  result_out = a - b;
      IOA_OP_MUL:  result_out = a * b;
      IOA_OP_DIV: begin
        // Zero divisor leaves the accumulator alone
        if (b == 32'sh0) ok_out = 1'b0;
        else result_out = a / b;
      end
      IOA_OP_MOD: begin
        if (b == 32'sh0) ok_out = 1'b0;
        else result_out = a % b;
      end
      IOA_OP_AND:  result_out = acc_in & operand_in;
      IOA_OP_OR:   result_out = acc_in | operand_in;
      IOA_OP_XOR:  result_out = acc_in ^ operand_in;
      IOA_OP_NOT:  result_out = ~acc_in;
      IOA_OP_LOAD: result_out = operand_in;
      default:     ok_out = 1'b0;
    endcase
  end

endmodule

// ---- logic/ioa_core.sv ----
// Executes read-I/O, set-output, accumulator arithmetic, compare and jump commands.
// Frames come from a byte receiver, stored-program commands arrive
// decoded; inputs and enable are pins, ADC words share this clock.
`timescale 1ns/1ps
module ioa_core
  import ioa_pkg::*;
(
  // Clock and reset
  input  wire logic             core_clk_in,
  input  wire logic             resetn_in,
  // Command frame bytes
  input  wire logic [7:0]       rx_byte_in,
  input  wire logic             rx_valid_in,
  output logic                  rx_ready_out,
  // Reply frame bytes
  output logic [7:0]            tx_byte_out,
  output logic                  tx_valid_out,
  input  wire logic             tx_ready_in,
  // Stored-program commands
  input  wire logic             prog_valid_in,
  input  wire logic [7:0]       prog_instr_in,
  input  wire logic [7:0]       prog_type_in,
  input  wire logic [7:0]       prog_bank_in,
  input  wire logic [31:0]      prog_value_in,
  output logic                  prog_ready_out,
  // Jump outcome
  output logic                  jump_done_out,
  output logic                  jump_taken_out,
  output logic [31:0]           jump_addr_out,
  // Pins and converter
  input  wire logic [3:0]       general_input_in,
  input  wire logic             enable_n_in,
  input  wire logic [3:0][15:0] adc_data_in,
  output logic [3:0]            general_output_out,
  // Internal state
  output logic [31:0]           accum_out,
  output logic [2:0]            cmp_flags_out
);

  typedef struct packed {
    ioa_state_t  st;
    logic        direct;
    logic [7:0]  instr;
    logic [7:0]  typ;
    logic [7:0]  bank;
    logic [31:0] val;
    logic [31:0] acc;
    logic        z;
    logic        gt;
    logic        lt;
    logic [3:0]  gout;
    logic [3:0]  gin_s1;
    logic [3:0]  gin_s2;
    logic        en_s1;
    logic        en_s2;
    logic [7:0]  rstat;
    logic [31:0] rval;
    logic [3:0]  idx;
    logic [7:0]  csum;
    logic [7:0]  txb;
    logic        txv;
    logic        pready;
    logic        jdone;
    logic        jtaken;
    logic [31:0] jaddr;
  } ioa_core_t;

  ioa_core_t   q;
  ioa_core_t   next_q;
  logic        take;
  logic        f_valid;
  logic [7:0]  f_instr;
  logic [7:0]  f_typ;
  logic [7:0]  f_bank;
  logic [31:0] f_val;
  logic [31:0] alu_res;
  logic        alu_ok;
  logic [32:0] rdv;

  // Returns {valid, value} for one port of one bank
  function automatic logic [32:0] read_io(
    input logic [7:0]       port,
    input logic [7:0]       bank,
    input logic [3:0]       gin,
    input logic [3:0]       gout,
    input logic             ena_n,
    input logic [3:0][15:0] adc
  );
    logic [32:0] r;
    r = {1'b0, 32'h00000000};
    if (port < IOA_NUM_IO) begin
      case (bank)
        IOA_BANK_DIN:  r = {1'b1, 31'h0, gin[port[1:0]]};
        IOA_BANK_AIN:  r = {1'b1, 16'h0, adc[port[1:0]]};
        IOA_BANK_DOUT: r = {1'b1, 31'h0, gout[port[1:0]]};
        default:       r = {1'b0, 32'h00000000};
      endcase
    end else if (bank == IOA_BANK_DIN && port == IOA_PORT_ALL) begin
      r = {1'b1, 28'h0, gin};
    end else if (bank == IOA_BANK_DIN && port == IOA_PORT_ENA) begin
      r = {1'b1, 31'h0, ena_n};
    end
    return r;
  endfunction

  function automatic logic jump_ok(
    input logic [7:0] c,
    input logic       z,
    input logic       gt,
    input logic       lt
  );
    case (c)
      IOA_JC_ZE: return z;
      IOA_JC_NZ: return !z;
      IOA_JC_EQ: return z;
      IOA_JC_NE: return !z;
      IOA_JC_GT: return gt;
      IOA_JC_GE: return gt || z;
      IOA_JC_LT: return lt;
      IOA_JC_LE: return lt || z;
      default:   return 1'b0;
    endcase
  endfunction

  function automatic logic [7:0] reply_byte(
    input logic [3:0]  i,
    input logic [7:0]  stat,
    input logic [7:0]  ins,
    input logic [31:0] v,
    input logic [7:0]  cs
  );
    case (i)
      4'h0:    return IOA_HOST_ADDR;
      4'h1:    return IOA_MOD_ADDR;
      4'h2:    return stat;
      4'h3:    return ins;
      4'h4:    return v[31:24];
      4'h5:    return v[23:16];
      4'h6:    return v[15:8];
      4'h7:    return v[7:0];
      default: return cs;
    endcase
  endfunction

  ioa_frame_rx u_rx (
    .core_clk_in     (core_clk_in),
    .resetn_in       (resetn_in),
    .rx_byte_in      (rx_byte_in),
    .rx_valid_in     (rx_valid_in),
    .rx_ready_out    (rx_ready_out),
    .take_in         (take),
    .frame_valid_out (f_valid),
    .instr_out       (f_instr),
    .type_out        (f_typ),
    .bank_out        (f_bank),
    .value_out       (f_val)
  );

  ioa_alu u_alu (
    .op_in      (q.typ),
    .acc_in     (q.acc),
    .operand_in (q.val),
    .result_out (alu_res),
    .ok_out     (alu_ok)
  );

  assign rdv = read_io(q.typ, q.bank, q.gin_s2, q.gout, q.en_s2,
                       adc_data_in);

  always_comb begin
    next_q        = q;
    take          = 1'b0;
    next_q.gin_s1 = general_input_in;
    next_q.gin_s2 = q.gin_s1;
    next_q.en_s1  = enable_n_in;
    next_q.en_s2  = q.en_s1;
    next_q.jdone  = 1'b0;
    case (q.st)
      IOA_ST_IDLE: begin
        // Program wins so its ready never lies
        if (prog_valid_in && q.pready) begin
          next_q.instr  = prog_instr_in;
          next_q.typ    = prog_type_in;
          next_q.bank   = prog_bank_in;
          next_q.val    = prog_value_in;
          next_q.direct = 1'b0;
          next_q.st     = IOA_ST_EXEC;
        end else if (f_valid) begin
          next_q.instr  = f_instr;
          next_q.typ    = f_typ;
          next_q.bank   = f_bank;
          next_q.val    = f_val;
          next_q.direct = 1'b1;
          take          = 1'b1;
          next_q.st     = IOA_ST_EXEC;
        end
      end
      IOA_ST_EXEC: begin
        next_q.rstat = IOA_STAT_OK;
        next_q.rval  = 32'h00000000;
        case (q.instr)
          IOA_CMD_READ_IO: begin
            if (!rdv[32]) begin
              next_q.rstat = IOA_STAT_BAD;
            end else begin
              next_q.rval = rdv[31:0];
              if (!q.direct || (q.bank == IOA_BANK_DIN &&
                                q.typ == IOA_PORT_ALL))
                next_q.acc = rdv[31:0];
            end
          end
          IOA_CMD_ARITH: begin
            next_q.rval = q.val;
            if (alu_ok) next_q.acc = alu_res;
            else next_q.rstat = IOA_STAT_BAD;
          end
          IOA_CMD_CMP: begin
            next_q.z    = q.acc == q.val;
            next_q.gt   = $signed(q.acc) > $signed(q.val);
            next_q.lt   = $signed(q.acc) < $signed(q.val);
            next_q.rval = q.val;
          end
          IOA_CMD_SET_OUT: begin
            if (q.bank == IOA_BANK_DOUT && q.typ < IOA_NUM_IO)
              next_q.gout[q.typ[1:0]] = q.val[0];
            else if (q.bank == IOA_BANK_DOUT && q.typ == IOA_PORT_ALL)
              next_q.gout = (q.val == IOA_ALL_ONES) ? q.acc[3:0]
                                                    : q.val[3:0];
            else
              next_q.rstat = IOA_STAT_BAD;
          end
          IOA_CMD_JUMP: begin
            // Only a stored program can jump
            if (q.direct) begin
              next_q.rstat = IOA_STAT_BAD;
            end else begin
              next_q.jdone  = 1'b1;
              next_q.jtaken = jump_ok(q.typ, q.z, q.gt, q.lt);
              next_q.jaddr  = q.val;
            end
          end
          default: next_q.rstat = IOA_STAT_BAD;
        endcase
        next_q.idx  = 4'h0;
        next_q.csum = 8'h00;
        next_q.st   = q.direct ? IOA_ST_REPLY : IOA_ST_IDLE;
      end
      IOA_ST_REPLY: begin
        if (!q.txv || tx_ready_in) begin
          if (q.idx < IOA_FRAME_LEN) begin
            next_q.txb  = reply_byte(q.idx, q.rstat, q.instr, q.rval,
                                     q.csum);
            next_q.txv  = 1'b1;
            next_q.csum = q.csum + next_q.txb;
            next_q.idx  = q.idx + 4'h1;
          end else begin
            next_q.txv = 1'b0;
            next_q.st  = IOA_ST_IDLE;
          end
        end
      end
      default: next_q.st = IOA_ST_IDLE;
    endcase
    next_q.pready = next_q.st == IOA_ST_IDLE;
  end

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in)
      q <= '{st: IOA_ST_IDLE, acc: IOA_ACC_RST, pready: 1'b1,
             default: '0};
    else
      q <= next_q;
  end

  assign tx_byte_out        = q.txb;
  assign tx_valid_out       = q.txv;
  assign prog_ready_out     = q.pready;
  assign jump_done_out      = q.jdone;
  assign jump_taken_out     = q.jtaken;
  assign jump_addr_out      = q.jaddr;
  assign general_output_out = q.gout;
  assign accum_out          = q.acc;
  assign cmp_flags_out      = {q.z, q.gt, q.lt};

  // Checks
  logic ex;
  logic rd;
  assign ex = q.st == IOA_ST_EXEC;
  assign rd = ex && q.instr == IOA_CMD_READ_IO && rdv[32];

  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);

  acc_hold_a: assert property (
    rd && q.direct && q.typ != IOA_PORT_ALL |=> $stable(q.acc))
    else $error("direct read changed accumulator");
  read_stat_a: assert property (
    rd && q.direct |=> q.rstat == IOA_STAT_OK && q.st == IOA_ST_REPLY)
    else $error("read reply status wrong");
  din_bit_a: assert property (
    rd && q.bank == IOA_BANK_DIN && q.typ == 8'h02
    |=> q.rval == {31'h0, $past(q.gin_s2[2])})
    else $error("digital input read wrong");
  vec_load_a: assert property (
    rd && q.bank == IOA_BANK_DIN && q.typ == IOA_PORT_ALL
    |=> q.acc == {28'h0, $past(q.gin_s2)})
    else $error("input vector not loaded");
  adc_read_a: assert property (
    rd && q.bank == IOA_BANK_AIN && q.typ == 8'h01
    |=> q.rval == {16'h0, $past(adc_data_in[1])})
    else $error("analog read wrong");
  ena_read_a: assert property (
    rd && q.bank == IOA_BANK_DIN && q.typ == IOA_PORT_ENA
    |=> q.rval == {31'h0, $past(q.en_s2)})
    else $error("enable read wrong");
  arith_echo_a: assert property (
    ex && q.instr == IOA_CMD_ARITH |=> q.rval == $past(q.val))
    else $error("arith reply not echoing operand");
  load_op_a: assert property (
    ex && q.instr == IOA_CMD_ARITH && q.typ == IOA_OP_LOAD
    |=> q.acc == $past(q.val))
    else $error("load did not set accumulator");
  cmp_flags_a: assert property (
    ex && q.instr == IOA_CMD_CMP
    |=> q.z == ($past(q.acc) == $past(q.val)) && !(q.gt && q.lt))
    else $error("compare flags wrong");
  set_out_a: assert property (
    ex && q.instr == IOA_CMD_SET_OUT && q.bank == IOA_BANK_DOUT &&
    q.typ == 8'h00 |=> q.gout[0] == $past(q.val[0]))
    else $error("output not set");
  hdr_byte_a: assert property (
    $rose(q.txv) |-> q.txb == IOA_HOST_ADDR && q.idx == 4'h1)
    else $error("reply does not open with host address");

endmodule

// ---- logic/ioa_frame_rx.sv ----
// Gathers nine-byte command frames and checks their checksum.
// Bytes arrive from a receiver on the same clock, one per valid.
`timescale 1ns/1ps
module ioa_frame_rx
  import ioa_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        resetn_in,
  // Byte stream
  input  wire logic [7:0]  rx_byte_in,
  input  wire logic        rx_valid_in,
  output logic             rx_ready_out,
  // Decoded frame
  input  wire logic        take_in,
  output logic             frame_valid_out,
  output logic [7:0]       instr_out,
  output logic [7:0]       type_out,
  output logic [7:0]       bank_out,
  output logic [31:0]      value_out
);

  typedef struct packed {
    logic [3:0]  cnt;
    logic [7:0]  sum;
    logic [63:0] sh;
    logic        full;
    logic        rdy;
  } ioa_rx_t;

  ioa_rx_t q;
  ioa_rx_t next_q;

  always_comb begin
    next_q = q;
    if (take_in) begin
      next_q.full = 1'b0;
      next_q.rdy  = 1'b1;
    end
    if (rx_valid_in && q.rdy) begin
      if (q.cnt == IOA_FRAME_LEN - 4'h1) begin
        next_q.cnt = 4'h0;
        next_q.sum = 8'h00;
        // Bad checksum or foreign address: dropped silently
        if (rx_byte_in == q.sum && q.sh[63:56] == IOA_MOD_ADDR) begin
          next_q.full = 1'b1;
          next_q.rdy  = 1'b0;
        end
      end else begin
        next_q.cnt = q.cnt + 4'h1;
        next_q.sum = q.sum + rx_byte_in;
        next_q.sh  = {q.sh[55:0], rx_byte_in};
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) q <= '{rdy: 1'b1, default: '0};
    else q <= next_q;
  end

  assign rx_ready_out    = q.rdy;
  assign frame_valid_out = q.full;
  assign instr_out       = q.sh[55:48];
  assign type_out        = q.sh[47:40];
  assign bank_out        = q.sh[39:32];
  assign value_out       = q.sh[31:0];

endmodule

// ---- logic/ioa_pkg.sv ----
// Constants for the I/O read and accumulator command block.
// Shared by the core and its helpers; holds no logic.
package ioa_pkg;

  // Instruction codes
  localparam logic [7:0] IOA_CMD_SET_OUT = 8'h0e;
  localparam logic [7:0] IOA_CMD_READ_IO = 8'h0f;
  localparam logic [7:0] IOA_CMD_ARITH   = 8'h13;
  localparam logic [7:0] IOA_CMD_CMP     = 8'h14;
  localparam logic [7:0] IOA_CMD_JUMP    = 8'h15;

  // Banks and special ports
  localparam logic [7:0] IOA_BANK_DIN  = 8'h00;
  localparam logic [7:0] IOA_BANK_AIN  = 8'h01;
  localparam logic [7:0] IOA_BANK_DOUT = 8'h02;
  localparam logic [7:0] IOA_PORT_ALL  = 8'hff;
  localparam logic [7:0] IOA_PORT_ENA  = 8'h0a;
  localparam logic [7:0] IOA_NUM_IO    = 8'h04;

  // Arithmetic selectors
  localparam logic [7:0] IOA_OP_ADD  = 8'h00;
  localparam logic [7:0] IOA_OP_SUB  = 8'h01;
  localparam logic [7:0] IOA_OP_MUL  = 8'h02;
  localparam logic [7:0] IOA_OP_DIV  = 8'h03;
  localparam logic [7:0] IOA_OP_MOD  = 8'h04;
  localparam logic [7:0] IOA_OP_AND  = 8'h05;
  localparam logic [7:0] IOA_OP_OR   = 8'h06;
  localparam logic [7:0] IOA_OP_XOR  = 8'h07;
  localparam logic [7:0] IOA_OP_NOT  = 8'h08;
  localparam logic [7:0] IOA_OP_LOAD = 8'h09;

  // Jump conditions
  localparam logic [7:0] IOA_JC_ZE = 8'h00;
  localparam logic [7:0] IOA_JC_NZ = 8'h01;
  localparam logic [7:0] IOA_JC_EQ = 8'h02;
  localparam logic [7:0] IOA_JC_NE = 8'h03;
  localparam logic [7:0] IOA_JC_GT = 8'h04;
  localparam logic [7:0] IOA_JC_GE = 8'h05;
  localparam logic [7:0] IOA_JC_LT = 8'h06;
  localparam logic [7:0] IOA_JC_LE = 8'h07;

  // Frames
  localparam logic [7:0]  IOA_STAT_OK   = 8'h64;
  localparam logic [7:0]  IOA_STAT_BAD  = 8'h02;
  localparam logic [7:0]  IOA_HOST_ADDR = 8'h02;
  localparam logic [7:0]  IOA_MOD_ADDR  = 8'h01;
  localparam logic [3:0]  IOA_FRAME_LEN = 4'h9;
  localparam logic [31:0] IOA_ALL_ONES  = 32'hffffffff;
  localparam logic [31:0] IOA_ACC_RST   = 32'h00000000;

  typedef enum logic [1:0] {
    IOA_ST_IDLE  = 2'b00,
    IOA_ST_EXEC  = 2'b01,
    IOA_ST_REPLY = 2'b10
  } ioa_state_t;

endpackage

// ---- testbench/ioa_core_tb.sv ----
// Self-checking bench for the command core, host model on frames.
// Assumes a 20 MHz clock and pins settled within two edges.
`timescale 1ns/1ps
module ioa_core_tb
  import ioa_pkg::*;
;
  logic             core_clk_in = 1'b0;
  logic             resetn_in = 1'b0;
  logic             prog_valid_in = 1'b0;
  logic             enable_n_in = 1'b0;
  logic [7:0]       prog_instr_in = 8'h00;
  logic [7:0]       prog_type_in = 8'h00;
  logic [7:0]       prog_bank_in = 8'h00;
  logic [31:0]      prog_value_in = 32'h0;
  logic [3:0]       general_input_in = 4'h0;
  logic [3:0][15:0] adc_data_in = '0;
  logic [7:0]       rx_byte_in, tx_byte_out;
  logic             rx_valid_in, rx_ready_out, tx_valid_out, tx_ready_in;
  logic             prog_ready_out, jump_done_out, jump_taken_out;
  logic [31:0]      jump_addr_out, accum_out;
  logic [3:0]       general_output_out;
  logic [2:0]       cmp_flags_out;
  logic [71:0]      rep;
  logic             hung;
  int               fails = 0;
  int               checked = 0;

  always #25 core_clk_in = ~core_clk_in;

  ioa_core ioa_core_inst (
    .core_clk_in, .resetn_in, .rx_byte_in, .rx_valid_in, .rx_ready_out,
    .tx_byte_out, .tx_valid_out, .tx_ready_in, .prog_valid_in,
    .prog_instr_in, .prog_type_in, .prog_bank_in, .prog_value_in,
    .prog_ready_out, .jump_done_out, .jump_taken_out, .jump_addr_out,
    .general_input_in, .enable_n_in, .adc_data_in, .general_output_out,
    .accum_out, .cmp_flags_out
  );

  ioa_host_model ioa_host_model_inst (
    .clk_in(core_clk_in), .rx_byte_out(rx_byte_in),
    .rx_valid_out(rx_valid_in), .rx_ready_in(rx_ready_out),
    .tx_byte_in(tx_byte_out), .tx_valid_in(tx_valid_out),
    .tx_ready_out(tx_ready_in), .rep_out(rep), .hung_out(hung)
  );

  task automatic results();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmd(input logic [7:0] ins, typ, bank,
                     input logic [31:0] val, exp, input bit slow);
    logic [7:0] s;
    ioa_host_model_inst.xact(ins, typ, bank, val, 1'b0, slow);
    chk(32'(hung), 32'h0);
    if (hung)
      results();
    s = 8'h00;
    for (int i = 1; i < 9; i++)
      s = s + rep[i*8 +: 8];
    chk(32'(rep[71:48]),
        {8'h00, IOA_HOST_ADDR, IOA_MOD_ADDR, IOA_STAT_OK});
    chk(32'(rep[47:40]), 32'(ins));
    chk(rep[39:8], exp);
    chk(32'(rep[7:0]), 32'(s));
  endtask

  task automatic rd(input int p, input logic [7:0] bank,
                    input logic [31:0] exp, input bit slow);
    cmd(IOA_CMD_READ_IO, p[7:0], bank, 32'h0, exp, slow);
  endtask

  task automatic prog(input logic [7:0] ins, typ, bank,
                      input logic [31:0] val);
    int n;
    @(posedge core_clk_in);
    prog_valid_in <= 1'b1;
    prog_instr_in <= ins;
    prog_type_in  <= typ;
    prog_bank_in  <= bank;
    prog_value_in <= val;
    n = 0;
    do begin
      @(posedge core_clk_in);
      n++;
    end while (prog_ready_out !== 1'b1 && n < 20);
    prog_valid_in <= 1'b0;
    chk(32'(n < 20), 32'h1);
    if (n >= 20)
      results();
    // Effects land one edge after the take; the jump pulse lasts one cycle
    @(posedge core_clk_in);
    #1;
  endtask

  task automatic t_reset();
    repeat (2) @(posedge core_clk_in);
    #1;
    chk(32'({rx_ready_out, prog_ready_out, tx_valid_out, jump_done_out}),
        32'hc);
    chk(accum_out, IOA_ACC_RST);
    chk(32'({general_output_out, cmp_flags_out}), 32'h0);
    @(posedge core_clk_in);
    resetn_in <= 1'b1;
  endtask

  task automatic t_outputs();
    cmd(IOA_CMD_SET_OUT, IOA_PORT_ALL, IOA_BANK_DOUT, 32'ha, 32'h0, 1'b0);
    chk(32'(general_output_out), 32'ha);
    cmd(IOA_CMD_SET_OUT, 8'h0, IOA_BANK_DOUT, 32'h1, 32'h0, 1'b0);
    chk(32'(general_output_out), 32'hb);
    for (int p = 0; p < 4; p++)
      rd(p, IOA_BANK_DOUT, {31'h0, p != 2}, 1'b0);
  endtask

  task automatic t_digital();
    general_input_in <= 4'h6;
    for (int p = 0; p < 4; p++)
      rd(p, IOA_BANK_DIN, {31'h0, p == 1 || p == 2}, 1'b0);
    chk(accum_out, 32'h0);
    rd(255, IOA_BANK_DIN, 32'h6, 1'b0);
    chk(accum_out, 32'h6);
    rd(10, IOA_BANK_DIN, 32'h0, 1'b0);
    enable_n_in <= 1'b1;
    rd(10, IOA_BANK_DIN, 32'h1, 1'b0);
  endtask

  task automatic t_analog();
    logic [3:0][15:0] a;
    a = {16'hffff, 16'h012e, 16'h8000, 16'h0001};
    adc_data_in <= a;
    for (int p = 0; p < 4; p++)
      rd(p, IOA_BANK_AIN, {16'h0, a[p]}, 1'b0);
    rd(1, IOA_BANK_DIN, 32'h1, 1'b0);
    prog(IOA_CMD_READ_IO, 8'h3, IOA_BANK_AIN, 32'h0);
    chk(accum_out, 32'hffff);
  endtask

  task automatic t_arith();
    logic [7:0]  op [12];
    logic [31:0] v [12];
    logic [31:0] e;
    op = '{8'h09, 8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06,
           8'h07, 8'h08, 8'h09, 8'h00};
    v = '{32'h000003e8, 32'hffffec78, 32'h7, 32'hfffffffd, 32'hfffffffc,
          32'h7, 32'hff, 32'h0f000001, 32'hffffffff, 32'h0,
          32'h7fffffff, 32'h1};
    e = 32'h0;
    for (int i = 0; i < 12; i++) begin
      case (op[i])
        0: e = e + v[i];
        1: e = e - v[i];
        2: e = e * v[i];
        3: e = $signed(e) / $signed(v[i]);
        4: e = $signed(e) % $signed(v[i]);
        5: e = e & v[i];
        6: e = e | v[i];
        7: e = e ^ v[i];
        8: e = ~e;
        default: e = v[i];
      endcase
      prog(IOA_CMD_ARITH, op[i], 8'h0, v[i]);
      chk(accum_out, e);
    end
    cmd(IOA_CMD_ARITH, IOA_OP_MUL, 8'h0, 32'hffffec78,
        32'hffffec78, 1'b1);
    chk(accum_out, e * 32'hffffec78);
  endtask

  task automatic t_compare();
    logic [7:0] tk;
    tk = 8'h3a;
    prog(IOA_CMD_ARITH, IOA_OP_LOAD, 8'h0, 32'hffffffff);
    cmd(IOA_CMD_CMP, 8'h0, 8'h0, 32'h1, 32'h1, 1'b0);
    chk(32'(cmp_flags_out), 32'h1);
    prog(IOA_CMD_CMP, 8'h0, 8'h0, 32'hffffffff);
    chk(32'(cmp_flags_out), 32'h4);
    prog(IOA_CMD_CMP, 8'h0, 8'h0, 32'hfffffffe);
    chk(32'(cmp_flags_out), 32'h2);
    for (int c = 0; c < 8; c++) begin
      prog(IOA_CMD_JUMP, c[7:0], 8'h0, 32'ha + c);
      chk(32'({jump_done_out, jump_taken_out}), 32'({1'b1, tk[c]}));
      chk(jump_addr_out, 32'ha + c);
    end
  endtask

  task automatic t_refuse();
    int n;
    ioa_host_model_inst.xact(IOA_CMD_READ_IO, 8'h0, IOA_BANK_DIN, 32'h0,
                             1'b1, 1'b0);
    n = 0;
    repeat (20) begin
      @(posedge core_clk_in);
      n += (tx_valid_out !== 1'b0);
    end
    chk(n, 0);
    chk(32'(rx_ready_out), 32'h1);
    rd(0, IOA_BANK_DIN, 32'h0, 1'b1);
  endtask

  initial begin
    t_reset();
    t_outputs();
    t_digital();
    t_analog();
    t_arith();
    t_compare();
    t_refuse();
    results();
  end
endmodule

// ---- testbench/ioa_host_model.sv ----
// Host model: sends nine-byte command frames and collects replies.
// Assumes the core's byte handshakes run on the same clock.
`timescale 1ns/1ps
module ioa_host_model
  import ioa_pkg::*;
(
  // Clock
  input  wire logic       clk_in,
  // Command bytes
  output logic [7:0]      rx_byte_out,
  output logic            rx_valid_out,
  input  wire logic       rx_ready_in,
  // Reply bytes
  input  wire logic [7:0] tx_byte_in,
  input  wire logic       tx_valid_in,
  output logic            tx_ready_out,
  // Last reply and stall flag
  output logic [71:0]     rep_out,
  output logic            hung_out
);
  initial begin
    rx_byte_out  = 8'h00;
    rx_valid_out = 1'b0;
    tx_ready_out = 1'b0;
    rep_out      = '0;
    hung_out     = 1'b0;
  end

  // Bad corrupts the checksum; slow stalls every reply byte after the first
  task automatic xact(input logic [7:0] ins, typ, bank,
                      input logic [31:0] val, input bit bad, slow);
    logic [71:0] f;
    int          n;
    bit          got;
    f = {IOA_MOD_ADDR, ins, typ, bank,
         val, 8'h00};
    for (int i = 1; i < 9; i++)
      f[7:0] = f[7:0] + f[i*8 +: 8];
    if (bad)
      f[0] = ~f[0];
    @(posedge clk_in);
    for (int i = 8; i >= 0; i--) begin
      rx_byte_out  <= f[i*8 +: 8];
      rx_valid_out <= 1'b1;
      n = 0;
      do begin
        @(posedge clk_in);
        n++;
      end while (rx_ready_in !== 1'b1 && n < 50);
      hung_out = hung_out | (n >= 50);
    end
    rx_valid_out <= 1'b0;
    // Released line shows the inverse, never a stale byte
    rx_byte_out  <= ~f[7:0];
    tx_ready_out <= !bad;
    for (int i = 0; i < 9 && !bad; i++) begin
      n = 0;
      do begin
        @(posedge clk_in);
        n++;
        got = tx_valid_in === 1'b1 && tx_ready_out === 1'b1;
        if (slow)
          tx_ready_out <= !got;
      end while (!got && n < 50);
      rep_out  = {rep_out[63:0], tx_byte_in};
      hung_out = hung_out | (n >= 50);
    end
    if (!slow && !bad)
      tx_ready_out <= 1'b0;
  endtask
endmodule
